// file: include/lod_defines.vh
`ifndef LOD_DEFINES_VH
`define LOD_DEFINES_VH

// ----------------------------------------
// Opcode bytes
// ----------------------------------------
`define LOD_ESCAPE        8'h0F
`define LOD_DSHR_IMM      8'hAC
`define LOD_DSHR_CNT      8'hAD
`define LOD_AND_RR        6'h08
`define LOD_OR_RR         6'h02
`define LOD_XOR_RR        6'h0C
`define LOD_AND_ACC       7'h12
`define LOD_OR_ACC        7'h06
`define LOD_XOR_ACC       7'h1A
`define LOD_TEST_RM       7'h42
`define LOD_TEST_ACC      7'h54
`define LOD_GRP_IMM       7'h40
`define LOD_GRP_UNARY     7'h7B
`define LOD_SUB_AND       3'h4
`define LOD_SUB_OR        3'h1
`define LOD_SUB_XOR       3'h6
`define LOD_SUB_TEST      3'h0
`define LOD_SUB_NOT       3'h2
`define LOD_MOD_REG       2'h3

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define LOD_OP_NONE       3'h0
`define LOD_OP_DSHR       3'h1
`define LOD_OP_AND        3'h2
`define LOD_OP_OR         3'h3
`define LOD_OP_XOR        3'h4
`define LOD_OP_TEST       3'h5
`define LOD_OP_NOT        3'h6

// ----------------------------------------
// Clock budgets
// ----------------------------------------
`define LOD_CLK_2         4'h2
`define LOD_CLK_3         4'h3
`define LOD_CLK_5         4'h5
`define LOD_CLK_6         4'h6
`define LOD_CLK_7         4'h7

`endif

// file: design/lod_clock_budget.v
`timescale 1ns/1ps
`default_nettype none
`include "lod_defines.vh"

module lod_clock_budget (
    input  wire [2:0] op,
    input  wire       memDest,
    input  wire       memSrc,
    input  wire       accForm,
    output reg  [3:0] clocks
);
    always @* begin
        clocks = 4'h0;
        case (op)
            `LOD_OP_DSHR: clocks = memDest ? `LOD_CLK_7 : `LOD_CLK_3;
            `LOD_OP_TEST:
                clocks = (memDest && !accForm) ? `LOD_CLK_5 : `LOD_CLK_2;
            `LOD_OP_NOT:  clocks = memDest ? `LOD_CLK_6 : `LOD_CLK_2;
            `LOD_OP_AND, `LOD_OP_OR, `LOD_OP_XOR: begin
                if (accForm)
                    clocks = `LOD_CLK_2;
                else if (memDest)
                    clocks = `LOD_CLK_7;
                else if (memSrc)
                    clocks = `LOD_CLK_6;
                else
                    clocks = `LOD_CLK_2;
            end
            default: clocks = 4'h0;
        endcase
    end
endmodule // lod_clock_budget

`default_nettype wire

// file: design/lod_logic_op_decoder.v
// Function
// - Escape plus AC: double right shift, immediate
// - Escape plus AD: double right shift, count register
// - Flag-only AND writes flags, never result
// - F6/F7 sub 000 decodes flag-only AND
// - A8/A9 immediate: accumulator flag-only AND
`timescale 1ns/1ps
`default_nettype none
`include "lod_defines.vh"

module lod_logic_op_decoder (
    input  wire       clk,
    input  wire       rst,
    input  wire       byteValid,
    input  wire [7:0] byteIn,
    output reg        decValid_q,
    output reg  [2:0] decOp_q,
    output reg        decFullSize_q,
    output reg        decRegIsDest_q,
    output reg        decMemOperand_q,
    output reg        decAccForm_q,
    output reg        decImmCount_q,
    output reg        decCountLow_q,
    output reg        decNeedImm_q,
    output reg        decWriteResult_q,
    output reg        decWriteFlags_q,
    output reg  [2:0] decRegField_q,
    output reg  [2:0] decRmField_q,
    output reg  [3:0] decClocks_q,
    output reg        decIllegal_q
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] ST_FIRST  = 3'b001;
    localparam [2:0] ST_SECOND = 3'b010;
    localparam [2:0] ST_MODRM  = 3'b100;

    reg  [2:0] state_q;
    reg  [2:0] state_d;
    reg  [2:0] op_q;
    reg  [2:0] op_d;
    reg        full_q;
    reg        full_d;
    reg        dirReg_q;
    reg        dirReg_d;
    reg        isShift_q;
    reg        isShift_d;
    reg        immCnt_q;
    reg        immCnt_d;
    reg        grpImm_q;
    reg        grpImm_d;
    reg        grpUnary_q;
    reg        grpUnary_d;
    reg        emit;
    reg  [2:0] eOp;
    reg        eMem;
    reg        eMemSrc;
    reg        eAcc;
    reg        eNeedImm;
    reg        eIllegal;
    reg        eRegDest;
    reg  [2:0] eReg;
    reg  [2:0] eRm;
    wire [3:0] eClocks;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [2:0] subOp;
        input [2:0] sub;
        input       unary;
        begin
            subOp = `LOD_OP_NONE;
            if (unary) begin
                if (sub == `LOD_SUB_TEST)
                    subOp = `LOD_OP_TEST;
                else if (sub == `LOD_SUB_NOT)
                    subOp = `LOD_OP_NOT;
            end else begin
                if (sub == `LOD_SUB_AND)
                    subOp = `LOD_OP_AND;
                else if (sub == `LOD_SUB_OR)
                    subOp = `LOD_OP_OR;
                else if (sub == `LOD_SUB_XOR)
                    subOp = `LOD_OP_XOR;
            end
        end
    endfunction

    function [2:0] rrOp;
        input [5:0] hi;
        begin
            case (hi)
                `LOD_AND_RR: rrOp = `LOD_OP_AND;
                `LOD_OR_RR:  rrOp = `LOD_OP_OR;
                `LOD_XOR_RR: rrOp = `LOD_OP_XOR;
                default:     rrOp = `LOD_OP_NONE;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    always @* begin
        state_d    = state_q;
        op_d       = op_q;
        full_d     = full_q;
        dirReg_d   = dirReg_q;
        isShift_d  = isShift_q;
        immCnt_d   = immCnt_q;
        grpImm_d   = grpImm_q;
        grpUnary_d = grpUnary_q;
        emit       = 1'b0;
        eOp        = `LOD_OP_NONE;
        eMem       = 1'b0;
        eMemSrc    = 1'b0;
        eAcc       = 1'b0;
        eNeedImm   = 1'b0;
        eIllegal   = 1'b0;
        eRegDest   = 1'b0;
        eReg       = 3'h0;
        eRm        = 3'h0;
        if (byteValid) begin
            case (state_q)
                ST_FIRST: begin
                    full_d     = byteIn[0];
                    dirReg_d   = byteIn[1];
                    isShift_d  = 1'b0;
                    grpImm_d   = 1'b0;
                    grpUnary_d = 1'b0;
                    op_d       = rrOp(byteIn[7:2]);
                    if (byteIn == `LOD_ESCAPE) begin
                        state_d = ST_SECOND;
                    end else if (op_d != `LOD_OP_NONE) begin
                        state_d = ST_MODRM;
                    end else if (byteIn[7:1] == `LOD_TEST_RM) begin
                        op_d     = `LOD_OP_TEST;
                        dirReg_d = 1'b0;
                        state_d  = ST_MODRM;
                    end else if (byteIn[7:1] == `LOD_GRP_IMM) begin
                        grpImm_d = 1'b1;
                        state_d  = ST_MODRM;
                    end else if (byteIn[7:1] == `LOD_GRP_UNARY) begin
                        // Bit 1 is fixed here, not a direction bit
                        grpUnary_d = 1'b1;
                        dirReg_d   = 1'b0;
                        state_d    = ST_MODRM;
                    end else begin
                        // Short accumulator forms skip the selector byte
                        emit     = 1'b1;
                        eAcc     = 1'b1;
                        eNeedImm = 1'b1;
                        eRegDest = 1'b1;
                        case (byteIn[7:1])
                            `LOD_TEST_ACC: eOp = `LOD_OP_TEST;
                            `LOD_AND_ACC:  eOp = `LOD_OP_AND;
                            `LOD_OR_ACC:   eOp = `LOD_OP_OR;
                            `LOD_XOR_ACC:  eOp = `LOD_OP_XOR;
                            default: begin
                                eAcc     = 1'b0;
                                eNeedImm = 1'b0;
                                eRegDest = 1'b0;
                                eIllegal = 1'b1;
                            end
                        endcase
                    end
                end
                ST_SECOND: begin
                    full_d    = 1'b1;
                    dirReg_d  = 1'b0;
                    isShift_d = 1'b1;
                    op_d      = `LOD_OP_DSHR;
                    if (byteIn == `LOD_DSHR_IMM) begin
                        immCnt_d = 1'b1;
                        state_d  = ST_MODRM;
                    end else if (byteIn == `LOD_DSHR_CNT) begin
                        immCnt_d = 1'b0;
                        state_d  = ST_MODRM;
                    end else begin
                        emit     = 1'b1;
                        eIllegal = 1'b1;
                        state_d  = ST_FIRST;
                    end
                end
                ST_MODRM: begin
                    emit     = 1'b1;
                    state_d  = ST_FIRST;
                    eReg     = byteIn[5:3];
                    eRm      = byteIn[2:0];
                    eOp      = op_q;
                    if (grpImm_q || grpUnary_q)
                        eOp = subOp(byteIn[5:3], grpUnary_q);
                    // Memory operand unless mod selects a register
                    eMem     = byteIn[7:6] != `LOD_MOD_REG;
                    eRegDest = dirReg_q;
                    eMemSrc  = eMem && dirReg_q;
                    if (eMemSrc)
                        eMem = 1'b0;
                    eNeedImm = grpImm_q || (isShift_q && immCnt_q)
                             || (grpUnary_q && eOp == `LOD_OP_TEST);
                    eIllegal = eOp == `LOD_OP_NONE;
                end
                default: state_d = ST_FIRST;
            endcase
        end
    end

    lod_clock_budget uBudget (
        .op      (eOp),
        .memDest (eMem),
        .memSrc  (eMemSrc),
        .accForm (eAcc),
        .clocks  (eClocks)
    );

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q          <= ST_FIRST;
            op_q             <= `LOD_OP_NONE;
            full_q           <= 1'b0;
            dirReg_q         <= 1'b0;
            isShift_q        <= 1'b0;
            immCnt_q         <= 1'b0;
            grpImm_q         <= 1'b0;
            grpUnary_q       <= 1'b0;
            decValid_q       <= 1'b0;
            decOp_q          <= `LOD_OP_NONE;
            decFullSize_q    <= 1'b0;
            decRegIsDest_q   <= 1'b0;
            decMemOperand_q  <= 1'b0;
            decAccForm_q     <= 1'b0;
            decImmCount_q    <= 1'b0;
            decCountLow_q    <= 1'b0;
            decNeedImm_q     <= 1'b0;
            decWriteResult_q <= 1'b0;
            decWriteFlags_q  <= 1'b0;
            decRegField_q    <= 3'h0;
            decRmField_q     <= 3'h0;
            decClocks_q      <= 4'h0;
            decIllegal_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            op_q       <= op_d;
            full_q     <= full_d;
            dirReg_q   <= dirReg_d;
            isShift_q  <= isShift_d;
            immCnt_q   <= immCnt_d;
            grpImm_q   <= grpImm_d;
            grpUnary_q <= grpUnary_d;
            decValid_q <= emit;
            if (emit) begin
                decOp_q          <= eIllegal ? `LOD_OP_NONE : eOp;
                decFullSize_q    <= full_d;
                decRegIsDest_q   <= eRegDest;
                decMemOperand_q  <= eMem || eMemSrc;
                decAccForm_q     <= eAcc;
                decImmCount_q    <= eOp == `LOD_OP_DSHR && immCnt_q;
                decCountLow_q    <= eOp == `LOD_OP_DSHR && !immCnt_q;
                decNeedImm_q     <= eNeedImm;
                // Compare-style op leaves the destination untouched
                decWriteResult_q <= !eIllegal && eOp != `LOD_OP_TEST;
                decWriteFlags_q  <= !eIllegal && eOp != `LOD_OP_NOT;
                decRegField_q    <= eReg;
                decRmField_q     <= eRm;
                decClocks_q      <= eIllegal ? 4'h0 : eClocks;
                decIllegal_q     <= eIllegal;
            end
        end
    end
endmodule // lod_logic_op_decoder

`default_nettype wire

// file: test/lod_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "lod_defines.vh"

module lod_decoder_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       byteValid,
    input wire logic [7:0] byteIn,
    input wire logic       decValid_q,
    input wire logic [2:0] decOp_q,
    input wire logic       decFullSize_q,
    input wire logic       decRegIsDest_q,
    input wire logic       decAccForm_q,
    input wire logic       decImmCount_q,
    input wire logic       decCountLow_q,
    input wire logic       decNeedImm_q,
    input wire logic       decWriteResult_q,
    input wire logic       decWriteFlags_q,
    input wire logic [3:0] decClocks_q,
    input wire logic       decIllegal_q
);
    // ------
    // Opcode boundary
    // ------
    // Boundary follows the valid pulse, so a silent decoder mutes these checks
    logic       busy_q;
    logic [1:0] mod_q;
    logic       firstW_q;
    logic       firstD_q;
    logic       dirForm_q;
    wire        firstByte = !busy_q || decValid_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'h0;
        end else if (byteValid && firstByte) begin
            busy_q <= 1'h1;
        end else if (decValid_q) begin
            busy_q <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        mod_q <= byteIn[7:6];
        if (byteValid && firstByte) begin
            firstW_q  <= byteIn[0];
            firstD_q  <= byteIn[1];
            dirForm_q <= byteIn[7:6] == 2'h0 && !byteIn[2] && (byteIn[5:3] == 3'h4
                         || byteIn[5:3] == 3'h1 || byteIn[5:3] == 3'h6);
        end
    end

    // ------
    // Properties
    // ------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sEscape(logic [7:0] second);
        firstByte && byteValid && byteIn == `LOD_ESCAPE ##1 byteValid && byteIn == second
        ##1 byteValid;
    endsequence

    sequence sGroup(logic [6:0] opc, logic [2:0] sub);
        firstByte && byteValid && byteIn[7:1] == opc ##1 byteValid && byteIn[5:3] == sub;
    endsequence

    chk_shift_imm_decode:
    assert property (sEscape(`LOD_DSHR_IMM) |=> decValid_q && decOp_q == `LOD_OP_DSHR
        && decImmCount_q && !decCountLow_q && decClocks_q == (mod_q == 2'h3 ? 4'h3 : 4'h7))
        else $error("immediate double shift decode wrong");
    chk_shift_cnt_decode:
    assert property (sEscape(`LOD_DSHR_CNT) |=> decValid_q && decOp_q == `LOD_OP_DSHR
        && decCountLow_q && !decImmCount_q && decClocks_q == (mod_q == 2'h3 ? 4'h3 : 4'h7))
        else $error("count register double shift decode wrong");
    chk_test_no_write:
    assert property (decValid_q && decOp_q == `LOD_OP_TEST |-> !decWriteResult_q
        && decWriteFlags_q) else $error("flag-only and writes a result");
    chk_test_imm_decode:
    assert property (sGroup(`LOD_GRP_UNARY, `LOD_SUB_TEST) |=> decValid_q && decNeedImm_q
        && decOp_q == `LOD_OP_TEST && decClocks_q == (mod_q == 2'h3 ? 4'h2 : 4'h5))
        else $error("immediate flag-only and decode wrong");
    chk_test_acc_short:
    assert property (firstByte && byteValid && byteIn[7:1] == `LOD_TEST_ACC |=> decValid_q
        && decOp_q == `LOD_OP_TEST && decAccForm_q && decNeedImm_q && decClocks_q == 4'h2)
        else $error("accumulator flag-only and decode wrong");
    chk_width_bit_size:
    assert property (decValid_q && !decIllegal_q |-> decFullSize_q == firstW_q)
        else $error("operand size does not follow width bit");
    chk_dir_bit_dest:
    assert property (decValid_q && dirForm_q |-> decRegIsDest_q == firstD_q)
        else $error("destination does not follow direction bit");
endmodule // lod_decoder_chk

bind lod_logic_op_decoder lod_decoder_chk lod_decoder_chk_inst (.clk(clk), .rst(rst),
    .byteValid(byteValid), .byteIn(byteIn), .decValid_q(decValid_q), .decOp_q(decOp_q),
    .decFullSize_q(decFullSize_q), .decRegIsDest_q(decRegIsDest_q),
    .decAccForm_q(decAccForm_q), .decImmCount_q(decImmCount_q),
    .decCountLow_q(decCountLow_q), .decNeedImm_q(decNeedImm_q),
    .decWriteResult_q(decWriteResult_q), .decWriteFlags_q(decWriteFlags_q),
    .decClocks_q(decClocks_q), .decIllegal_q(decIllegal_q));

`default_nettype wire

// file: test/lod_testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "lod_defines.vh"

module testbench;
    // ------
    // Signals
    // ------
    logic       clk = 1'h0;
    logic       rst = 1'h1;
    logic       byteValid = 1'h0;
    logic [7:0] byteIn = 8'h00;
    wire        vld, full, dir, mem, acc, immc, cntl, nimm, wres, wflg, ill;
    wire [2:0]  op;
    wire [3:0]  clks;
    wire [2:0]  regF, rmF;
    wire [16:0] seenVec = {ill, op, clks, full, dir, mem, acc, immc, cntl, nimm, wres, wflg};
    integer     errorCnt = 0;
    integer     checksDone = 0;
    integer     cycles = 0;
    integer     seed = 32'hA82E;

    lod_logic_op_decoder lod_logic_op_decoder_inst (.clk(clk), .rst(rst),
        .byteValid(byteValid), .byteIn(byteIn), .decValid_q(vld), .decOp_q(op),
        .decFullSize_q(full), .decRegIsDest_q(dir), .decMemOperand_q(mem), .decAccForm_q(acc),
        .decImmCount_q(immc), .decCountLow_q(cntl), .decNeedImm_q(nimm),
        .decWriteResult_q(wres), .decWriteFlags_q(wflg), .decRegField_q(regF),
        .decRmField_q(rmF), .decClocks_q(clks), .decIllegal_q(ill));

    always #10 clk = ~clk;

    // Run is about 1150 cycles, so this ceiling only trips on a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            errorCnt = errorCnt + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checksDone = checksDone + 1;
        if (seen !== exp) begin
            errorCnt = errorCnt + 1;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic [2:0] sub_op(input [2:0] sub);
        sub_op = sub == `LOD_SUB_AND ? `LOD_OP_AND : sub == `LOD_SUB_OR ? `LOD_OP_OR
               : sub == `LOD_SUB_XOR ? `LOD_OP_XOR : `LOD_OP_NONE;
    endfunction

    // Returns byte count, compare mask and expected fields
    function automatic [35:0] expect_dec(input [7:0] b0, input [7:0] b1, input [7:0] b2);
        reg [2:0] eo;
        reg [3:0] c;
        reg [7:0] s;
        reg       sh, d, m, a, ni, il, grp;
        begin
            sh = b0 == `LOD_ESCAPE;
            grp = b0[7:1] == `LOD_GRP_UNARY || b0[7:1] == `LOD_GRP_IMM;
            s = sh ? b2 : b1;
            m = s[7:6] != `LOD_MOD_REG;
            eo = `LOD_OP_NONE;
            c = 4'h0;
            d = 1'h0;
            a = 1'h0;
            ni = 1'h0;
            casez (b0)
                `LOD_ESCAPE: if (b1[7:1] == 7'h56) begin
                    eo = `LOD_OP_DSHR;
                    c = m ? 4'h7 : 4'h3;
                    ni = !b1[0];
                end
                8'b00??_?0??: begin
                    eo = sub_op(b0[5:3]);
                    d = b0[1];
                    c = !m ? 4'h2 : d ? 4'h6 : 4'h7;
                end
                8'b00??_?10?: a = 1'h1;
                8'b1000_000?: begin
                    eo = sub_op(s[5:3]);
                    c = m ? 4'h7 : 4'h2;
                    ni = 1'h1;
                end
                8'b1000_010?: begin
                    eo = `LOD_OP_TEST;
                    c = m ? 4'h5 : 4'h2;
                end
                8'b1111_011?: begin
                    eo = s[5:3] == 3'h0 ? `LOD_OP_TEST : s[5:3] == 3'h2 ? `LOD_OP_NOT : 3'h0;
                    c = !m ? 4'h2 : s[5:3] == 3'h0 ? 4'h5 : 4'h6;
                    ni = s[5:3] == 3'h0;
                end
                8'b1010_100?: a = 1'h1;
                default: ;
            endcase
            if (a) begin
                eo = b0[7] ? `LOD_OP_TEST : sub_op(b0[5:3]);
                c = 4'h2;
                d = 1'h1;
                ni = 1'h1;
                m = 1'h0;
            end
            il = eo == `LOD_OP_NONE;
            if (il) c = 4'h0;
            expect_dec = {sh ? (il ? 2'h2 : 2'h3) : (a || (il && !grp)) ? 2'h1 : 2'h2,
                il ? 17'h1FE01 : sh ? 17'h1FF7F : 17'h1FFFF, il, eo, c, sh | b0[0], d, m, a,
                sh & !il & !b1[0], sh & !il & b1[0], ni, !il && eo != `LOD_OP_TEST,
                !il && eo != `LOD_OP_NOT};
        end
    endfunction

    task automatic drive(input [7:0] b);
        @(posedge clk);
        byteValid <= 1'h1;
        byteIn <= b;
    endtask

    task automatic issue(input [7:0] b0, input [7:0] b1, input [7:0] b2);
        logic [35:0] e;
        logic [16:0] mk;
        logic [7:0]  s;
        begin
            e = expect_dec(b0, b1, b2);
            mk = e[33:17];
            // Fields exist only once a selector byte was taken
            s = e[35:34] == 2'h1 || (b0 == `LOD_ESCAPE && e[35:34] == 2'h2) ? 8'h00
              : b0 == `LOD_ESCAPE ? b2 : b1;
            drive(b0);
            if (e[35:34] > 2'h1) drive(b1);
            if (e[35:34] > 2'h2) drive(b2);
            @(posedge clk);
            byteValid <= 1'h0;
            #1;
            check("valid", vld, 1'h1);
            check("decode", seenVec & mk & 17'h1FE7C, e[16:0] & mk & 17'h1FE7C);
            check("writes", seenVec & mk & 17'h00003, e[16:0] & mk & 17'h00003);
            check("sizing", seenVec & mk & 17'h00180, e[16:0] & mk & 17'h00180);
            check("fields", {regF, rmF}, s[5:0]);
        end
    endtask

    // ------
    // Stimulus
    // ------
    initial begin
        logic [31:0] r;
        logic [2:0]  sub;
        repeat (2) @(posedge clk);
        check("reset", {vld, seenVec, regF, rmF}, 24'h0);
        rst <= 1'h0;
        issue(8'h0F, `LOD_DSHR_IMM, 8'hC1);
        issue(8'h0F, `LOD_DSHR_IMM, 8'h01);
        issue(8'h0F, `LOD_DSHR_CNT, 8'h3A);
        issue(8'hF7, 8'h06, 8'h00);
        issue(8'hF6, 8'hD0, 8'h00);
        drive(8'hA9);
        issue(8'hA8, 8'h00, 8'h00);
        issue(8'h81, 8'h38, 8'h00);
        // Reset in mid-escape must drop the half-taken opcode
        drive(8'h0F);
        @(posedge clk);
        byteValid <= 1'h0;
        rst <= 1'h1;
        @(posedge clk);
        check("midreset", {vld, seenVec, regF, rmF}, 24'h0);
        rst <= 1'h0;
        issue(8'hA8, 8'h00, 8'h00);
        repeat (400) begin
            r = $random(seed);
            sub = r[9:8] == 2'h0 ? 3'h4 : r[9:8] == 2'h1 ? 3'h1 : 3'h6;
            case (r[16:14])
                3'h0: issue(8'h0F, {7'h56, r[12]}, r[7:0]);
                3'h1: issue({2'h0, sub, 1'h0, r[11:10]}, r[7:0], 8'h00);
                3'h2: issue({2'h0, sub, 2'h2, r[10]}, 8'h00, 8'h00);
                3'h3: issue({7'h40, r[10]}, {r[7:6], sub, r[2:0]}, 8'h00);
                3'h4: issue({7'h7B, r[10]}, {r[7:6], 1'h0, r[12:11], r[2:0]}, 8'h00);
                3'h5: issue({7'h42, r[10]}, r[7:0], 8'h00);
                3'h6: issue({7'h54, r[10]}, 8'h00, 8'h00);
                default: issue(r[12] ? 8'hFF : 8'h0F, 8'hA4, 8'h00);
            endcase
        end
        summarize();
    end
endmodule // testbench

`default_nettype wire
